// >>> inc/fds_pkg.sv
`default_nettype none
package fds_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // i/o port numbers
   localparam logic [2:0] PORT_CTRL1 = 3'h0;
   localparam logic [2:0] PORT_SERIAL = 3'h1;
   localparam logic [2:0] PORT_KEY = 3'h2;
   localparam logic [2:0] PORT_CTRL2 = 3'h3;
   localparam logic [2:0] PORT_PHCLR = 3'h4;
   localparam logic [2:0] PORT_MODCLR = 3'h5;

   ////////////////////////////////////////////////////////////////////////////
   // control/status one fields
   localparam int CTRL1_MUTE = 7;
   localparam int CTRL1_FAST = 6;
   localparam int CTRL1_DMAEN = 5;
   localparam int CTRL1_CSN = 4;
   localparam logic [7:0] CTRL1_WMASK = 8'hF0;
   localparam logic [7:0] CTRL1_RESET = 8'h10;

   // control/status two fields
   localparam int CTRL2_WE2 = 1;
   localparam int CTRL2_WE1 = 0;
   localparam logic [7:0] CTRL2_WMASK = 8'h03;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_MHZ = 40;
   localparam int SPI_BITS = 8;
   localparam int SPI_SLOW_DIV = 256;
   localparam int SPI_FAST_HALF = 1;
   localparam logic [7:0] SPI_SLOW_HALF_M1 = 8'(SPI_SLOW_DIV / 2 - 1);
   localparam logic [7:0] SPI_FAST_HALF_M1 = 8'(SPI_FAST_HALF - 1);
   localparam logic [11:0] SPI_FAST_BYTE_CYC = 12'(2 * SPI_BITS * SPI_FAST_HALF);
   localparam logic [11:0] SPI_SLOW_BYTE_CYC = 12'(SPI_BITS * SPI_SLOW_DIV);
   localparam int DISK_BITS = 8;
   localparam int DISK_BYTE_NS = 30720;
   localparam int DISK_BIT_CYC = DISK_BYTE_NS * CLK_MHZ / (1000 * DISK_BITS);
   localparam int RD_PULSE_NS = 1000;
   localparam int RD_PULSE_CYC = (RD_PULSE_NS * CLK_MHZ + 999) / 1000;

   ////////////////////////////////////////////////////////////////////////////
   // track buffer
   localparam int DMA_ADDR_W = 14;
   localparam logic [13:0] DMA_BASE = 14'h1200;
   localparam int TRACK_PLAY_BYTES = 6392;
   localparam int TRACK_STORED_BYTES = 6656;
   localparam logic [13:0] DMA_END = DMA_BASE + 14'(TRACK_PLAY_BYTES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // carriers and codes
   typedef struct packed {
      logic [2:0] addr;
      logic wrStb;
      logic rdStb;
      logic [7:0] wrData;
   } fds_io_t;

   typedef struct packed {
      logic [3:0] phase;
      logic drive_select;
      logic motor;
      logic wrData;
      logic wrReq;
      logic miso;
   } fds_pins_t;

   typedef enum logic [1:0] {
      OWN_VIDEO = 2'h0,
      OWN_CPU = 2'h1,
      OWN_DMA = 2'h2
   } fds_owner_t;

   typedef enum logic [1:0] {
      DMA_IDLE = 2'h0,
      DMA_RD_PEND = 2'h1,
      DMA_WR_PEND = 2'h2
   } fds_dma_t;

endpackage : fds_pkg
`default_nettype wire

// >>> hw/fds_spi_master.sv
`timescale 1ns/10ps
`default_nettype none
module fds_spi_master
   import fds_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic fast,
   input wire logic start,
   input wire logic [7:0] txByte,
   input wire logic miso,
   output logic busy,
   output logic [7:0] rxByte,
   output logic sck,
   output logic mosi
);

   logic [7:0] ctrl_q;
   logic [7:0] data_q;
   logic [7:0] divCnt_q;
   logic misoBit_q;
   logic sck_q;
   logic mosi_q;
   logic [7:0] halfM1;
   logic tick;

   assign busy = ctrl_q[7];
   assign rxByte = data_q;
   assign sck = sck_q;
   assign mosi = mosi_q;

   ////////////////////////////////////////////////////////////////////////////
   // fast or prescaled rate
   assign halfM1 = fast ? SPI_FAST_HALF_M1 : SPI_SLOW_HALF_M1;
   assign tick = busy && (divCnt_q == halfM1);

   always_ff @(posedge clock) begin
      if (rst || start || tick) begin
         divCnt_q <= 8'h00;
      end else if (busy) begin
         divCnt_q <= divCnt_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ones mark the busy span
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_q <= 8'h00;
      end else if (start) begin
         ctrl_q <= 8'hFF;
      end else if (tick && sck_q) begin
         ctrl_q <= {ctrl_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sck_q <= 1'b0;
         mosi_q <= 1'b0;
         data_q <= 8'h00;
      end else if (start) begin
         sck_q <= 1'b0;
         mosi_q <= txByte[7];
         data_q <= txByte;
      end else if (tick) begin
         sck_q <= ~sck_q;
         if (sck_q) begin
            data_q <= {data_q[6:0], misoBit_q};
            mosi_q <= data_q[6];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         misoBit_q <= 1'b0;
      end else if (tick && !sck_q) begin
         misoBit_q <= miso;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // busy span counter, read only by the checks
   logic [11:0] busyCnt_q;
   logic fastAtStart_q;

   always_ff @(posedge clock) begin
      if (rst || start) begin
         busyCnt_q <= 12'h000;
         fastAtStart_q <= fast;
      end else if (busy) begin
         busyCnt_q <= busyCnt_q + 12'h001;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence sStartLoad;
      start ##1 busy;
   endsequence

   chk_mode_zero: assert property (
      $changed(mosi_q) |-> ($fell(sck_q) || $past(start)))
      else $error("mosi moved away from a falling clock");
   chk_miso_sample: assert property (
      $rose(sck_q) |-> misoBit_q == $past(miso))
      else $error("miso not sampled at rising clock");
   chk_busy_start: assert property (
      start |-> sStartLoad)
      else $error("busy not raised after data write");
   chk_busy_span: assert property (
      ($fell(busy) && $past(!start)) |->
         busyCnt_q == (fastAtStart_q ? SPI_FAST_BYTE_CYC : SPI_SLOW_BYTE_CYC))
      else $error("busy span is not eight serial clocks");

endmodule : fds_spi_master
`default_nettype wire

// >>> hw/fds_floppy_dma_spi_io.sv
`timescale 1ns/10ps
`default_nettype none
module fds_floppy_dma_spi_io
   import fds_pkg::*;
#(
   parameter int unsigned BIT_CYCLES = DISK_BIT_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire fds_io_t ioReq,
   output logic [7:0] ioRdData,
   output logic irq,
   input wire logic [7:0] keyCode,
   input wire logic keyStrobe,
   output logic keyboardMute,
   input wire fds_pins_t pins,
   output logic diskRdPulse,
   output logic [1:0] driveWriteEnable,
   input wire logic vidRead,
   input wire logic cpuMemReq,
   input wire logic [7:0] memRdData,
   output fds_owner_t memOwner,
   output logic [13:0] dmaMemAddr,
   output logic [7:0] dmaMemWrData,
   output logic dmaMemRd,
   output logic dmaMemWr,
   output logic spiSck,
   output logic spiMosi,
   output logic cardSelectN
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   fds_pins_t pinMeta_q;
   fds_pins_t pin_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         pinMeta_q <= '0;
         pin_q <= '0;
      end else begin
         pinMeta_q <= pins;
         pin_q <= pinMeta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // port decode
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic [7:0] keyCode_q;
   logic keyValid_q;
   logic [3:0] phaseFlags_q;
   logic [3:0] phasePrev_q;
   logic [3:0] phaseRise;
   logic dirty_q;
   logic irq_q;
   logic [7:0] ioRdData_q;
   logic spiBusy;
   logic [7:0] spiRx;
   logic wrCtrl1;
   logic wrSerial;
   logic wrCtrl2;
   logic wrPhClr;
   logic wrModClr;
   logic keyRead;
   logic anyFlag;

   assign wrCtrl1 = ioReq.wrStb && (ioReq.addr == PORT_CTRL1);
   assign wrSerial = ioReq.wrStb && (ioReq.addr == PORT_SERIAL);
   assign wrCtrl2 = ioReq.wrStb && (ioReq.addr == PORT_CTRL2);
   assign wrPhClr = ioReq.wrStb && (ioReq.addr == PORT_PHCLR);
   assign wrModClr = ioReq.wrStb && (ioReq.addr == PORT_MODCLR);
   assign keyRead = ioReq.rdStb && (ioReq.addr == PORT_KEY);

   assign ioRdData = ioRdData_q;
   assign irq = irq_q;
   assign keyboardMute = ctrl1_q[CTRL1_MUTE];
   assign cardSelectN = ctrl1_q[CTRL1_CSN];
   assign driveWriteEnable = ctrl2_q[1:0];

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl1_q <= CTRL1_RESET;
      end else if (wrCtrl1) begin
         ctrl1_q <= ioReq.wrData & CTRL1_WMASK;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl2_q <= CTRL2_RESET;
      end else if (wrCtrl2) begin
         ctrl2_q <= ioReq.wrData & CTRL2_WMASK;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         keyValid_q <= 1'b0;
         keyCode_q <= 8'h00;
      end else if (keyStrobe) begin
         keyValid_q <= 1'b1;
         keyCode_q <= keyCode;
      end else if (keyRead) begin
         keyValid_q <= 1'b0;
      end
   end

   assign phaseRise = pin_q.phase & ~phasePrev_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         phasePrev_q <= 4'h0;
         phaseFlags_q <= 4'h0;
      end else begin
         phasePrev_q <= pin_q.phase;
         phaseFlags_q <= (wrPhClr ? 4'h0 : phaseFlags_q) | phaseRise;
      end
   end

   assign anyFlag = |phaseFlags_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= anyFlag;
      end
   end

   // serial port reads last received byte
   always_ff @(posedge clock) begin
      if (rst) begin
         ioRdData_q <= RD_UNMAPPED;
      end else if (ioReq.rdStb) begin
         unique case (ioReq.addr)
            PORT_CTRL1: ioRdData_q <= {ctrl1_q[7:4], pin_q.drive_select, pin_q.motor,
                                       spiBusy, keyValid_q};
            PORT_SERIAL: ioRdData_q <= spiRx;
            PORT_KEY: ioRdData_q <= keyCode_q;
            PORT_CTRL2: ioRdData_q <= {phaseFlags_q, 1'b0, dirty_q, ctrl2_q[1:0]};
            default: ioRdData_q <= RD_UNMAPPED;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial master; slow transfers must be polled, fast ones finish in time
   fds_spi_master u_spi (
      .clock(clock),
      .rst(rst),
      .fast(ctrl1_q[CTRL1_FAST]),
      .start(wrSerial),
      .txByte(ioReq.wrData),
      .miso(pin_q.miso),
      .busy(spiBusy),
      .rxByte(spiRx),
      .sck(spiSck),
      .mosi(spiMosi)
   );

   ////////////////////////////////////////////////////////////////////////////
   // disk bit timing
   logic dmaEn;
   logic [15:0] bitCnt_q;
   logic [2:0] bitIdx_q;
   logic bitTick;
   logic byteTick;

   assign dmaEn = ctrl1_q[CTRL1_DMAEN];
   assign bitTick = dmaEn && (bitCnt_q == 16'(BIT_CYCLES - 1));
   // one memory cycle per eight bits
   assign byteTick = bitTick && (bitIdx_q == 3'h7);

   always_ff @(posedge clock) begin
      if (rst || !dmaEn || bitTick) begin
         bitCnt_q <= 16'h0000;
      end else begin
         bitCnt_q <= bitCnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || !dmaEn) begin
         bitIdx_q <= 3'h0;
      end else if (bitTick) begin
         bitIdx_q <= bitIdx_q + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read stream
   logic [7:0] rdBuf_q;
   logic [7:0] rdShift_q;
   logic rdLate_q;
   logic diskRdPulse_q;

   assign diskRdPulse = diskRdPulse_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         rdShift_q <= 8'h00;
      end else if (byteTick) begin
         rdShift_q <= rdBuf_q;
      end else if (bitTick) begin
         rdShift_q <= {rdShift_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         diskRdPulse_q <= 1'b0;
      end else begin
         diskRdPulse_q <= dmaEn && rdShift_q[7] && (bitCnt_q < 16'(RD_PULSE_CYC));
      end
   end

   // ram answers one cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         rdLate_q <= 1'b0;
         rdBuf_q <= 8'h00;
      end else begin
         rdLate_q <= dmaMemRd;
         if (rdLate_q) begin
            rdBuf_q <= memRdData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write stream
   logic wrPrev_q;
   logic [7:0] wrShift_q;
   logic [7:0] wrBuf_q;
   logic nrzBit;
   logic writing;

   assign nrzBit = pin_q.wrData ^ wrPrev_q;
   assign writing = pin_q.wrReq &&
                    (pin_q.drive_select ? ctrl2_q[CTRL2_WE2] : ctrl2_q[CTRL2_WE1]);

   always_ff @(posedge clock) begin
      if (rst) begin
         wrPrev_q <= 1'b0;
         wrShift_q <= 8'h00;
      end else if (bitTick) begin
         wrPrev_q <= pin_q.wrData;
         wrShift_q <= {wrShift_q[6:0], nrzBit};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wrBuf_q <= 8'h00;
      end else if (byteTick && writing) begin
         wrBuf_q <= {wrShift_q[6:0], nrzBit};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address counter and memory cycles
   logic [13:0] dmaAddr_q;
   logic [13:0] addrNext;
   logic [13:0] opAddr_q;
   fds_dma_t dmaState_q;
   fds_owner_t owner;
   logic dmaGrant;

   assign addrNext = (dmaAddr_q == DMA_END) ? DMA_BASE : dmaAddr_q + 14'h0001;

   always_ff @(posedge clock) begin
      if (rst) begin
         dmaAddr_q <= DMA_BASE;
         opAddr_q <= DMA_BASE;
      end else if (byteTick) begin
         dmaAddr_q <= addrNext;
         opAddr_q <= writing ? dmaAddr_q : addrNext;
      end
   end

   assign owner = vidRead ? OWN_VIDEO : (cpuMemReq ? OWN_CPU : OWN_DMA);
   assign dmaGrant = (owner == OWN_DMA);

   always_ff @(posedge clock) begin
      if (rst) begin
         memOwner <= OWN_VIDEO;
      end else begin
         memOwner <= owner;
      end
   end

   // dropping the enable abandons a pending cycle
   always_ff @(posedge clock) begin
      if (rst || !dmaEn) begin
         dmaState_q <= DMA_IDLE;
         dmaMemRd <= 1'b0;
         dmaMemWr <= 1'b0;
         dmaMemAddr <= DMA_BASE;
         dmaMemWrData <= 8'h00;
      end else begin
         dmaMemRd <= 1'b0;
         dmaMemWr <= 1'b0;
         if (byteTick) begin
            dmaState_q <= writing ? DMA_WR_PEND : DMA_RD_PEND;
         end else begin
            unique case (dmaState_q)
               DMA_IDLE: dmaState_q <= DMA_IDLE;
               DMA_RD_PEND: if (dmaGrant) begin
                  dmaMemRd <= 1'b1;
                  dmaMemAddr <= opAddr_q;
                  dmaState_q <= DMA_IDLE;
               end
               DMA_WR_PEND: if (dmaGrant) begin
                  dmaMemWr <= 1'b1;
                  dmaMemAddr <= opAddr_q;
                  dmaMemWrData <= wrBuf_q;
                  dmaState_q <= DMA_IDLE;
               end
               default: dmaState_q <= DMA_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         dirty_q <= 1'b0;
      end else if (dmaEn && !byteTick && dmaGrant && (dmaState_q == DMA_WR_PEND)) begin
         dirty_q <= 1'b1;
      end else if (wrModClr) begin
         dirty_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence sReadCycle;
      dmaMemRd ##1 rdLate_q;
   endsequence

   chk_arb_video: assert property (
      vidRead |=> memOwner == OWN_VIDEO)
      else $error("video lost memory ownership");
   chk_dma_yield: assert property (
      (dmaMemRd || dmaMemWr) |-> $past(dmaGrant))
      else $error("dma cycle without free memory");
   chk_addr_wrap: assert property (
      (byteTick && dmaAddr_q == DMA_END) |=> dmaAddr_q == DMA_BASE)
      else $error("address did not wrap to base");
   chk_nrz_xor: assert property (
      bitTick |=> wrShift_q[0] == $past(nrzBit))
      else $error("write stream not xor decoded");
   chk_read_fetch: assert property (
      sReadCycle |=> rdBuf_q == $past(memRdData))
      else $error("read buffer missed memory data");
   chk_pulse_gate: assert property (
      diskRdPulse_q |-> $past(rdShift_q[7]) && $past(dmaEn))
      else $error("read pulse without a one bit");
   chk_dirty_write: assert property (
      dmaMemWr |-> dirty_q)
      else $error("modified flag not set by dma write");
   chk_phase_clear: assert property (
      (wrPhClr && phaseRise == 4'h0) |=> phaseFlags_q == 4'h0)
      else $error("phase flags survived clear strobe");
   chk_irq_level: assert property (
      irq_q == $past(anyFlag))
      else $error("interrupt does not follow phase flags");
   chk_key_clear: assert property (
      (keyRead && !keyStrobe) |=> !keyValid_q)
      else $error("key valid not cleared by read");
   chk_strobe_ignore: assert property (
      (wrPhClr || wrModClr) |=> $stable(ctrl1_q) && $stable(ctrl2_q))
      else $error("clear strobe altered a control register");

endmodule : fds_floppy_dma_spi_io
`default_nettype wire

// >>> dv/fds_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module fds_far_side
   import fds_pkg::*;
(
   input wire logic clock,
   input wire logic spiSck,
   input wire logic cardSelectN,
   input wire logic [7:0] cardByte,
   output logic miso,
   input wire logic [13:0] dmaMemAddr,
   input wire logic [7:0] dmaMemWrData,
   input wire logic dmaMemRd,
   input wire logic dmaMemWr,
   output logic [7:0] memRdData
);
   logic [7:0] mem [16384];
   logic [7:0] sh = 8'h00;
   logic sckQ = 1'b0;
   logic csnQ = 1'b1;
   initial miso = 1'b0;
   initial memRdData = 8'h00;
   initial foreach (mem[i]) mem[i] = 8'(i);
   ////////////////////////////////////////////////////////////////////////////
   // card answer, moves on falls
   always @(posedge clock) begin
      sckQ <= spiSck;
      csnQ <= cardSelectN;
      if (cardSelectN) begin
         sh <= cardByte;
         miso <= ~miso;
      end else if (csnQ) begin
         miso <= sh[7];
      end else if (sckQ && !spiSck) begin
         sh <= {sh[6:0], 1'b0};
         miso <= sh[6];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // ram answer one cycle on; idle bus wanders
   always @(posedge clock) begin
      memRdData <= dmaMemRd ? mem[dmaMemAddr] : ~memRdData;
      if (dmaMemWr) begin
         mem[dmaMemAddr] <= dmaMemWrData;
      end
   end
endmodule : fds_far_side
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import fds_pkg::*;
;
   localparam int BITC = 1;
   typedef struct packed {
      logic [2:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } fds_row_t;
   localparam fds_row_t ROWS [6] = '{'{PORT_CTRL1, 8'hD0, 8'hD4},
      '{PORT_CTRL1, 8'h0F, 8'h04}, '{PORT_CTRL2, 8'hFE, 8'h02},
      '{PORT_CTRL2, 8'h01, 8'h01}, '{3'h6, 8'hFF, 8'h00}, '{3'h7, 8'hFF, 8'h00}};
   logic clock = 1'b0;
   logic rst = 1'b1;
   fds_io_t ioReq = '0;
   logic [7:0] keyCode = 8'h00;
   logic keyStrobe = 1'b0;
   logic [3:0] phase = 4'h0;
   logic wrPin = 1'b1;
   logic wrReq = 1'b0;
   logic vidRead = 1'b0;
   logic cpuMemReq = 1'b0;
   logic toggleOn = 1'b0;
   logic [15:0] tbCyc = '0;
   logic [15:0] lastCyc = '0;
   logic [13:0] lastAddr = '0;
   logic [7:0] lastWr = '0;
   logic [7:0] mosiCap = '0;
   logic watch = 1'b0;
   logic haveAddr = 1'b0;
   logic wrapped = 1'b0;
   int n_fail = 0;
   int checks_done = 0;
   int nWr = 0;
   int nStb = 0;
   int nPulse = 0;
   logic miso, irq, keyboardMute, diskRdPulse, dmaMemRd, dmaMemWr, spiSck, spiMosi;
   logic cardSelectN;
   logic [7:0] ioRdData, memRdData, dmaMemWrData;
   logic [1:0] driveWriteEnable;
   logic [13:0] dmaMemAddr;
   fds_owner_t memOwner;
   wire fds_pins_t pins;
   assign pins = {phase, 1'b0, 1'b1, wrPin, wrReq, miso};
   always #12.5 clock = ~clock;
   fds_floppy_dma_spi_io #(.BIT_CYCLES(BITC)) fds_floppy_dma_spi_io_i (.clock(clock),
      .rst(rst), .ioReq(ioReq), .ioRdData(ioRdData), .irq(irq), .keyCode(keyCode),
      .keyStrobe(keyStrobe), .keyboardMute(keyboardMute), .pins(pins),
      .diskRdPulse(diskRdPulse), .driveWriteEnable(driveWriteEnable), .vidRead(vidRead),
      .cpuMemReq(cpuMemReq), .memRdData(memRdData), .memOwner(memOwner),
      .dmaMemAddr(dmaMemAddr), .dmaMemWrData(dmaMemWrData), .dmaMemRd(dmaMemRd),
      .dmaMemWr(dmaMemWr), .spiSck(spiSck), .spiMosi(spiMosi), .cardSelectN(cardSelectN));
   fds_far_side fds_far_side_i (.clock(clock), .spiSck(spiSck), .cardSelectN(cardSelectN),
      .cardByte(8'h3C), .miso(miso), .dmaMemAddr(dmaMemAddr), .dmaMemWrData(dmaMemWrData),
      .dmaMemRd(dmaMemRd), .dmaMemWr(dmaMemWr), .memRdData(memRdData));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic io(input logic wr, input logic [2:0] a, input logic [7:0] d);
      ioReq <= '{addr: a, wrStb: wr, rdStb: !wr, wrData: d};
      @(posedge clock);
      ioReq <= '0;
      @(posedge clock);
   endtask : io
   // busy seen through back-to-back status reads, one cycle late
   task automatic spi(input logic [7:0] tx, input int cyc);
      int n;
      n = 0;
      ioReq <= '{addr: PORT_SERIAL, wrStb: 1'b1, rdStb: 1'b0, wrData: tx};
      @(posedge clock);
      ioReq <= '{addr: PORT_CTRL1, wrStb: 1'b0, rdStb: 1'b1, wrData: 8'h00};
      for (int i = 0; i < 2200; i++) begin
         @(negedge clock);
         if (ioRdData[1] === 1'b1) n++;
         else if (n > 0) break;
      end
      @(posedge clock);
      ioReq <= '0;
      @(posedge clock);
      cmp(16'(n), 16'(cyc));
   endtask : spi
   task automatic waitWr(input int k);
      int n0;
      n0 = nWr;
      for (int i = 0; i < 2000 && nWr < n0 + k; i++) @(posedge clock);
   endtask : waitWr
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      tbCyc <= tbCyc + 16'h0001;
      wrPin <= toggleOn ? tbCyc[0] : 1'b1;
   end
   always @(posedge spiSck) mosiCap <= {mosiCap[6:0], spiMosi};
   always @(negedge clock) begin
      if (diskRdPulse === 1'b1) nPulse++;
   end
   always @(negedge clock) begin
      if (dmaMemRd === 1'b1 || dmaMemWr === 1'b1) begin
         nStb++;
         if (dmaMemWr === 1'b1) begin
            nWr++;
            lastWr = dmaMemWrData;
         end
         if (watch && haveAddr) begin
            cmp(16'(dmaMemAddr), 16'(lastAddr == DMA_END ? DMA_BASE : lastAddr + 1));
            cmp(tbCyc - lastCyc, 16'(8 * BITC));
         end
         wrapped |= watch && haveAddr && dmaMemAddr == DMA_BASE;
         haveAddr = watch;
         lastAddr = dmaMemAddr;
         lastCyc = tbCyc;
      end
   end
   initial begin
      repeat (70000) @(posedge clock);
      n_fail++;
      $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int n0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      cmp(16'({cardSelectN, irq, dmaMemAddr}), 16'h9200);
      foreach (ROWS[i]) begin
         io(1'b1, ROWS[i].a, ROWS[i].d);
         io(1'b0, ROWS[i].a, 8'h00);
         cmp(16'(ioRdData), 16'(ROWS[i].e));
         if (ROWS[i].a == PORT_CTRL1) begin
            cmp(16'({keyboardMute, cardSelectN}), 16'({ROWS[i].e[7], ROWS[i].e[4]}));
         end else if (ROWS[i].a == PORT_CTRL2) begin
            cmp(16'(driveWriteEnable), 16'(ROWS[i].e[1:0]));
         end
      end
      keyCode <= 8'h5A;
      keyStrobe <= 1'b1;
      @(posedge clock);
      keyStrobe <= 1'b0;
      io(1'b0, PORT_CTRL1, 8'h00);
      cmp(16'(ioRdData[0]), 16'h0001);
      io(1'b0, PORT_KEY, 8'h00);
      cmp(16'(ioRdData), 16'h005A);
      io(1'b0, PORT_CTRL1, 8'h00);
      cmp(16'(ioRdData[0]), 16'h0000);
      phase <= 4'h4;
      repeat (6) @(posedge clock);
      phase <= 4'h0;
      repeat (6) @(posedge clock);
      io(1'b0, PORT_CTRL2, 8'h00);
      cmp(16'({irq, ioRdData}), 16'h0141);
      io(1'b1, PORT_PHCLR, 8'h00);
      io(1'b0, PORT_CTRL2, 8'h00);
      cmp(16'({irq, ioRdData}), 16'h0001);
      for (int i = 0; i < 3; i++) begin
         vidRead <= (i == 0);
         cpuMemReq <= (i < 2);
         repeat (2) @(posedge clock);
         cmp(16'(memOwner), 16'(i));
      end
      io(1'b1, PORT_CTRL1, 8'h40);
      spi(8'hA5, 16);
      cmp(16'(mosiCap), 16'h00A5);
      io(1'b1, PORT_CTRL1, 8'h10);
      io(1'b1, PORT_CTRL1, 8'h00);
      spi(8'hFF, 2048);
      io(1'b0, PORT_SERIAL, 8'h00);
      cmp(16'(ioRdData), 16'h003C);
      // dma writes to drive one, first steady then toggling stream
      wrReq <= 1'b1;
      io(1'b1, PORT_CTRL1, 8'h30);
      waitWr(3);
      cmp(16'(lastWr), 16'h0000);
      toggleOn <= 1'b1;
      waitWr(3);
      cmp(16'(lastWr), 16'h00FF);
      wrReq <= 1'b0;
      vidRead <= 1'b1;
      n0 = nStb;
      repeat (60) @(posedge clock);
      cmp(16'(nStb - n0), 16'h0000);
      vidRead <= 1'b0;
      io(1'b0, PORT_CTRL2, 8'h00);
      cmp(16'(ioRdData), 16'h0005);
      io(1'b1, PORT_MODCLR, 8'hFF);
      io(1'b0, PORT_CTRL2, 8'h00);
      cmp(16'(ioRdData), 16'h0001);
      watch = 1'b1;
      for (int i = 0; i < 60000 && !wrapped; i++) @(posedge clock);
      cmp(16'(wrapped), 16'h0001);
      // processor parks the dma before reusing the buffer
      io(1'b1, PORT_CTRL1, 8'h10);
      n0 = nStb;
      repeat (20) @(posedge clock);
      cmp(16'(nStb - n0), 16'h0000);
      cmp(16'({nPulse > 0, diskRdPulse}), 16'h0002);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
